// [rtl/phymm_pkg.sv]
// Constants and carrier types of the PHY management main register bank
package phymm_pkg;

   // Register indices
   localparam logic [4:0] IDX_MODE_CTL = 5'h00;
   localparam logic [4:0] IDX_MODE_STS = 5'h01;
   localparam logic [4:0] IDX_RSVD_A = 5'h0B;
   localparam logic [4:0] IDX_RSVD_B = 5'h0C;
   localparam logic [4:0] IDX_EXT_LO = 5'h10;
   localparam logic [4:0] IDX_EXT_HI = 5'h1E;
   localparam logic [4:0] IDX_RSVD_C = 5'h1B;
   localparam logic [4:0] IDX_PAGE = 5'h1F;

   // Mode control bit positions
   localparam int CTL_SOFT_RESET = 15;
   localparam int CTL_LOOPBACK = 14;
   localparam int CTL_SPEED_LO = 13;
   localparam int CTL_AN_ENABLE = 12;
   localparam int CTL_POWER_DOWN = 11;
   localparam int CTL_AN_RESTART = 9;
   localparam int CTL_DUPLEX = 8;
   localparam int CTL_SPEED_HI = 6;

   // Mode status bit positions
   localparam int STS_AN_DONE = 5;
   localparam int STS_REM_FAULT = 4;
   localparam int STS_LINK = 2;
   localparam int STS_JABBER = 1;

   // Status bits that never change: abilities, extended status, extended capabilities
   localparam logic [15:0] STS_FIXED = 16'h7909;
   localparam logic [15:0] PAGE_RESET = 16'h0000;
   localparam logic [15:0] PAGE_EXT1 = 16'h0001;
   localparam logic [15:0] PAGE_EXT2 = 16'h0002;

   // Control fields after reset
   localparam logic RST_AN_ENABLE = 1'b1;
   localparam logic RST_SPEED_HI = 1'b1;

   // Speed codes as {high, low}
   localparam logic [1:0] SPEED_10 = 2'h0;
   localparam logic [1:0] SPEED_100 = 2'h1;
   localparam logic [1:0] SPEED_1000 = 2'h2;

   // Page codes of the forwarded access
   localparam logic [1:0] PG_MAIN = 2'h0;
   localparam logic [1:0] PG_EXT1 = 2'h1;
   localparam logic [1:0] PG_EXT2 = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_FWD = 2'b10
   } phymm_state_e;

   // One management access as offered by the MAC
   typedef struct packed {
      logic write;
      logic [4:0] index;
      logic [15:0] wdata;
   } phymm_req_s;

   // Mode settings handed to the PHY core
   typedef struct packed {
      logic softReset;
      logic anRestart;
      logic loopback;
      logic anEnable;
      logic powerDown;
      logic forcedValid;
      logic [1:0] forcedSpeed;
      logic forcedDuplex;
   } phymm_ctl_s;

   // Conditions reported by the PHY core
   typedef struct packed {
      logic linkUp;
      logic anDone;
      logic remoteFault;
      logic jabber;
      logic resetTaken;
      logic restartTaken;
   } phymm_cond_s;

endpackage : phymm_pkg

// [rtl/phymm_main_regs.sv]
// Management register bank: page select, mode control and mode status
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module phymm_main_regs (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clkEn,
   // Management access from the MAC, same clock
   input wire logic mgmtReq,
   input wire phymm_pkg::phymm_req_s mgmtCmd,
   output logic mgmtAck,
   output logic [15:0] mgmtRdata,
   output logic mgmtBusy,
   // Accesses to registers held outside this bank
   output logic fwdReq,
   output phymm_pkg::phymm_req_s fwdCmd,
   output logic [1:0] fwdPage,
   input wire logic fwdAck,
   input wire logic [15:0] fwdRdata,
   // PHY core side
   output phymm_pkg::phymm_ctl_s modeCtl,
   input wire phymm_pkg::phymm_cond_s coreCond
);

   ////////////////////////////////////////////////////////////////////////////
   // Conditions from the PHY core cross in through two flops

   phymm_pkg::phymm_cond_s condMeta;
   phymm_pkg::phymm_cond_s condSync;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         condMeta <= '0;
         condSync <= '0;
      end else if (clkEn) begin
         condMeta <= coreCond;
         condSync <= condMeta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   function automatic logic isExtRange(input logic [4:0] idx);
      isExtRange = (idx >= phymm_pkg::IDX_EXT_LO) && (idx <= phymm_pkg::IDX_EXT_HI);
   endfunction : isExtRange

   function automatic logic isLocal(input logic [4:0] idx, input logic [1:0] pg);
      logic hit;
      hit = (idx == phymm_pkg::IDX_MODE_CTL) || (idx == phymm_pkg::IDX_MODE_STS);
      hit = hit || (idx == phymm_pkg::IDX_PAGE);
      hit = hit || (idx == phymm_pkg::IDX_RSVD_A) || (idx == phymm_pkg::IDX_RSVD_B);
      // Index 27 is only reserved on the main page
      hit = hit || ((idx == phymm_pkg::IDX_RSVD_C) && (pg == phymm_pkg::PG_MAIN));
      isLocal = hit;
   endfunction : isLocal

   ////////////////////////////////////////////////////////////////////////////
   // Access sequencing

   phymm_pkg::phymm_state_e state;
   logic take;
   logic takeLocal;
   logic wrCtl;
   logic wrPage;
   logic rdSts;
   logic [15:0] pageReg;
   logic [1:0] pageSel;
   logic [1:0] reqPage;

   // Only the values 1 and 2 open an extended page; anything else stays on main
   assign pageSel = (pageReg == phymm_pkg::PAGE_EXT1) ? phymm_pkg::PG_EXT1 :
                    (pageReg == phymm_pkg::PAGE_EXT2) ? phymm_pkg::PG_EXT2 :
                    phymm_pkg::PG_MAIN;

   assign reqPage = isExtRange(mgmtCmd.index) ? pageSel : phymm_pkg::PG_MAIN;

   assign take = clkEn && mgmtReq && (state == phymm_pkg::ST_IDLE);
   assign takeLocal = take && isLocal(mgmtCmd.index, reqPage);
   assign wrCtl = takeLocal && mgmtCmd.write && (mgmtCmd.index == phymm_pkg::IDX_MODE_CTL);
   assign wrPage = takeLocal && mgmtCmd.write && (mgmtCmd.index == phymm_pkg::IDX_PAGE);
   assign rdSts = takeLocal && !mgmtCmd.write && (mgmtCmd.index == phymm_pkg::IDX_MODE_STS);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state <= phymm_pkg::ST_IDLE;
      end else if (clkEn) begin
         unique case (state)
            phymm_pkg::ST_IDLE: begin
               if (take && !takeLocal) begin
                  state <= phymm_pkg::ST_FWD;
               end
            end
            phymm_pkg::ST_FWD: begin
               if (fwdAck) begin
                  state <= phymm_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= phymm_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Busy mirrors the state so the MAC holds off while an outside register answers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mgmtBusy <= 1'b0;
      end else if (clkEn) begin
         mgmtBusy <= (take && !takeLocal) || ((state == phymm_pkg::ST_FWD) && !fwdAck);
      end
   end

   // Forwarded access: one-cycle request, command held until the answer
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fwdReq <= 1'b0;
         fwdCmd <= '0;
         fwdPage <= phymm_pkg::PG_MAIN;
      end else if (clkEn) begin
         fwdReq <= take && !takeLocal;
         if (take && !takeLocal) begin
            fwdCmd <= mgmtCmd;
            fwdPage <= reqPage;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Page selection register

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pageReg <= phymm_pkg::PAGE_RESET;
      end else if (clkEn && wrPage) begin
         pageReg <= mgmtCmd.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode control register

   logic resetBit;
   logic restartBit;
   logic loopBit;
   logic speedLoBit;
   logic anEnBit;
   logic pdBit;
   logic duplexBit;
   logic [15:0] ctlWord;
   logic [15:0] stsWord;
   logic linkLatch;

   // A taken soft reset puts the settings back to their reset values
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         loopBit <= 1'b0;
         speedLoBit <= 1'b0;
         anEnBit <= phymm_pkg::RST_AN_ENABLE;
         pdBit <= 1'b0;
         duplexBit <= 1'b0;
      end else if (clkEn) begin
         if (wrCtl) begin
            loopBit <= mgmtCmd.wdata[phymm_pkg::CTL_LOOPBACK];
            speedLoBit <= mgmtCmd.wdata[phymm_pkg::CTL_SPEED_LO];
            anEnBit <= mgmtCmd.wdata[phymm_pkg::CTL_AN_ENABLE];
            pdBit <= mgmtCmd.wdata[phymm_pkg::CTL_POWER_DOWN];
            duplexBit <= mgmtCmd.wdata[phymm_pkg::CTL_DUPLEX];
         end else if (resetBit && condSync.resetTaken) begin
            loopBit <= 1'b0;
            speedLoBit <= 1'b0;
            anEnBit <= phymm_pkg::RST_AN_ENABLE;
            pdBit <= 1'b0;
            duplexBit <= 1'b0;
         end
      end
   end

   // Self-clearing bits: a new write of 1 wins over the core's acknowledgement
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         resetBit <= 1'b0;
         restartBit <= 1'b0;
      end else if (clkEn) begin
         if (wrCtl && mgmtCmd.wdata[phymm_pkg::CTL_SOFT_RESET]) begin
            resetBit <= 1'b1;
         end else if (condSync.resetTaken) begin
            resetBit <= 1'b0;
         end
         if (wrCtl && mgmtCmd.wdata[phymm_pkg::CTL_AN_RESTART]) begin
            restartBit <= 1'b1;
         end else if (condSync.restartTaken || (resetBit && condSync.resetTaken)) begin
            restartBit <= 1'b0;
         end
      end
   end

   always_comb begin
      ctlWord = '0;
      ctlWord[phymm_pkg::CTL_SOFT_RESET] = resetBit;
      ctlWord[phymm_pkg::CTL_LOOPBACK] = loopBit;
      ctlWord[phymm_pkg::CTL_SPEED_LO] = speedLoBit;
      ctlWord[phymm_pkg::CTL_AN_ENABLE] = anEnBit;
      ctlWord[phymm_pkg::CTL_POWER_DOWN] = pdBit;
      ctlWord[phymm_pkg::CTL_AN_RESTART] = restartBit;
      ctlWord[phymm_pkg::CTL_DUPLEX] = duplexBit;
      ctlWord[phymm_pkg::CTL_SPEED_HI] = phymm_pkg::RST_SPEED_HI;
   end

   // Settings to the core; forced speed and duplex only count without negotiation
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         modeCtl <= '0;
      end else if (clkEn) begin
         modeCtl.softReset <= resetBit;
         modeCtl.anRestart <= restartBit;
         modeCtl.loopback <= loopBit;
         modeCtl.anEnable <= anEnBit;
         modeCtl.powerDown <= pdBit;
         modeCtl.forcedValid <= !anEnBit;
         modeCtl.forcedSpeed <= {phymm_pkg::RST_SPEED_HI, speedLoBit};
         modeCtl.forcedDuplex <= duplexBit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode status register

   // Link loss wins over the re-arm that a status read does in the same cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         linkLatch <= 1'b0;
      end else if (clkEn) begin
         if (!condSync.linkUp) begin
            linkLatch <= 1'b0;
         end else if (rdSts) begin
            linkLatch <= 1'b1;
         end
      end
   end

   always_comb begin
      stsWord = phymm_pkg::STS_FIXED;
      stsWord[phymm_pkg::STS_AN_DONE] = condSync.anDone;
      stsWord[phymm_pkg::STS_REM_FAULT] = condSync.remoteFault;
      stsWord[phymm_pkg::STS_LINK] = linkLatch;
      stsWord[phymm_pkg::STS_JABBER] = condSync.jabber;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Answer to the MAC

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mgmtAck <= 1'b0;
         mgmtRdata <= '0;
      end else if (clkEn) begin
         mgmtAck <= takeLocal || ((state == phymm_pkg::ST_FWD) && fwdAck);
         if (takeLocal && !mgmtCmd.write) begin
            unique case (mgmtCmd.index)
               phymm_pkg::IDX_MODE_CTL: mgmtRdata <= ctlWord;
               phymm_pkg::IDX_MODE_STS: mgmtRdata <= stsWord;
               phymm_pkg::IDX_PAGE: mgmtRdata <= pageReg;
               // Reserved indices answer zero so the MAC never hangs
               default: mgmtRdata <= '0;
            endcase
         end else if ((state == phymm_pkg::ST_FWD) && fwdAck) begin
            mgmtRdata <= fwdCmd.write ? 16'h0000 : fwdRdata;
         end
      end
   end

endmodule : phymm_main_regs

// [dv/phymm_far_model.sv]
// Far-side model: outside register store and PHY core action handshake
`timescale 1ns/1ps
module phymm_far_model (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [3:0] lat,
   input wire logic [5:0] cond,
   input wire logic fwdReq,
   input wire phymm_pkg::phymm_req_s fwdCmd,
   input wire logic [1:0] fwdPage,
   output logic fwdAck,
   output logic [15:0] fwdRdata,
   input wire phymm_pkg::phymm_ctl_s modeCtl,
   output phymm_pkg::phymm_cond_s coreCond
);
   logic [15:0] mem [0:3][0:31];
   logic [3:0] waitCnt, rstCnt, rsaCnt;
   logic pend;
   phymm_pkg::phymm_req_s cmd;
   logic [1:0] pg;
   initial mem = '{default: '{default: 16'h0000}};
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pend <= 1'b0;
         fwdAck <= 1'b0;
         fwdRdata <= 16'h0000;
         waitCnt <= 4'h0;
      end else begin
         fwdAck <= 1'b0;
         // Data is only good in the answer cycle
         fwdRdata <= ~fwdRdata;
         if (fwdReq) begin
            pend <= 1'b1;
            waitCnt <= lat;
            cmd <= fwdCmd;
            pg <= fwdPage;
         end else if (pend && waitCnt != 4'h0) begin
            waitCnt <= waitCnt - 4'h1;
         end else if (pend) begin
            pend <= 1'b0;
            fwdAck <= 1'b1;
            if (cmd.write) mem[pg][cmd.index] <= cmd.wdata;
            else fwdRdata <= mem[pg][cmd.index];
         end
      end
   end
   // Core takes an action after 8 cycles and holds until the request drops
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rstCnt <= 4'h0;
         rsaCnt <= 4'h0;
      end else begin
         rstCnt <= !modeCtl.softReset ? 4'h0 : rstCnt + {3'h0, rstCnt != 4'h8};
         rsaCnt <= !modeCtl.anRestart ? 4'h0 : rsaCnt + {3'h0, rsaCnt != 4'h8};
      end
   end
   assign coreCond = {cond[5:2], rstCnt == 4'h8, rsaCnt == 4'h8};
endmodule : phymm_far_model

// [dv/phymm_main_regs_checker.sv]
// Port-level assertions of the management register bank
`timescale 1ns/1ps
module phymm_main_regs_chk (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic mgmtReq,
   input wire phymm_pkg::phymm_req_s mgmtCmd,
   input wire logic mgmtAck,
   input wire logic [15:0] mgmtRdata,
   input wire logic mgmtBusy,
   input wire logic fwdReq,
   input wire phymm_pkg::phymm_req_s fwdCmd,
   input wire logic [1:0] fwdPage,
   input wire logic fwdAck,
   input wire logic [15:0] fwdRdata,
   input wire phymm_pkg::phymm_ctl_s modeCtl,
   input wire phymm_pkg::phymm_cond_s coreCond
);
   logic take, rdSts, rdCtl;
   assign take = clkEn && mgmtReq && !mgmtBusy && !fwdReq;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdSts <= 1'b0;
         rdCtl <= 1'b0;
      end else if (clkEn) begin
         rdSts <= take && !mgmtCmd.write && mgmtCmd.index == phymm_pkg::IDX_MODE_STS;
         rdCtl <= take && !mgmtCmd.write && mgmtCmd.index == phymm_pkg::IDX_MODE_CTL;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence sLocal; take && mgmtCmd.index inside {5'h00, 5'h01, 5'h1F}; endsequence
   sequence sLowFwd; take && mgmtCmd.index inside {[5'h02:5'h0A], [5'h0D:5'h0F]}; endsequence
   sequence sFwdRd; fwdAck && mgmtBusy && !fwdCmd.write; endsequence
   sequence sCtlWr; take && mgmtCmd.write && mgmtCmd.index == 5'h00; endsequence
   ack_local_a: assert property (sLocal |=> mgmtAck && !fwdReq)
      else $error("local access not answered");
   low_main_a: assert property (sLowFwd |=> fwdReq && fwdPage == phymm_pkg::PG_MAIN)
      else $error("low index left the main page");
   fwd_cmd_a: assert property (fwdReq |-> fwdCmd == $past(mgmtCmd))
      else $error("forwarded command differs");
   fwd_ans_a: assert property (sFwdRd |=> mgmtAck && !mgmtBusy && mgmtRdata == $past(fwdRdata))
      else $error("forwarded read answer wrong");
   sts_fixed_a: assert property (rdSts |-> mgmtAck && (mgmtRdata & 16'hFF09) == 16'h7909)
      else $error("fixed status bits wrong");
   speed_hi_a: assert property (rdCtl |-> mgmtAck && mgmtRdata[6])
      else $error("speed high bit not 1");
   loop_follow_a: assert property (sCtlWr |-> ##2 modeCtl.loopback == $past(mgmtCmd.wdata[14], 2))
      else $error("loopback not applied");
   reset_clear_a: assert property ($rose(coreCond.resetTaken) && modeCtl.softReset |-> ##[1:6] !modeCtl.softReset)
      else $error("soft reset stuck");
endmodule : phymm_main_regs_chk
bind phymm_main_regs phymm_main_regs_chk i_phymm_main_regs_chk (.core_clk(core_clk), .rstn(rstn),
   .clkEn(clkEn), .mgmtReq(mgmtReq), .mgmtCmd(mgmtCmd), .mgmtAck(mgmtAck), .mgmtRdata(mgmtRdata),
   .mgmtBusy(mgmtBusy), .fwdReq(fwdReq), .fwdCmd(fwdCmd), .fwdPage(fwdPage), .fwdAck(fwdAck),
   .fwdRdata(fwdRdata), .modeCtl(modeCtl), .coreCond(coreCond));

// [dv/tb_top.sv]
// Self-checking bench of the management register bank
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_top;
   logic core_clk = 1'b0, rstn = 1'b0, clkEn = 1'b1, mgmtReq = 1'b0;
   logic mgmtAck, mgmtBusy, fwdReq, fwdAck;
   logic [15:0] mgmtRdata, fwdRdata, rd;
   logic [1:0] fwdPage;
   logic [5:0] cond = 6'h00;
   logic [3:0] lat = 4'h0;
   phymm_pkg::phymm_req_s mgmtCmd = '0, fwdCmd;
   phymm_pkg::phymm_ctl_s modeCtl;
   phymm_pkg::phymm_cond_s coreCond;
   int err_total = 0, compares = 0, cycles = 0;
   always #5 core_clk = ~core_clk;
   phymm_main_regs i_phymm_main_regs (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn),
      .mgmtReq(mgmtReq), .mgmtCmd(mgmtCmd), .mgmtAck(mgmtAck), .mgmtRdata(mgmtRdata),
      .mgmtBusy(mgmtBusy), .fwdReq(fwdReq), .fwdCmd(fwdCmd), .fwdPage(fwdPage),
      .fwdAck(fwdAck), .fwdRdata(fwdRdata), .modeCtl(modeCtl), .coreCond(coreCond));
   phymm_far_model i_phymm_far_model (.core_clk(core_clk), .rstn(rstn), .lat(lat), .cond(cond),
      .fwdReq(fwdReq), .fwdCmd(fwdCmd), .fwdPage(fwdPage), .fwdAck(fwdAck),
      .fwdRdata(fwdRdata), .modeCtl(modeCtl), .coreCond(coreCond));
   ////////////////////////////////////////////////////////////
   task automatic acc(input logic w, input logic [4:0] idx, input logic [15:0] wd);
      int n;
      n = 0;
      @(posedge core_clk);
      mgmtReq <= 1'b1;
      mgmtCmd <= '{write: w, index: idx, wdata: wd};
      @(posedge core_clk);
      mgmtReq <= 1'b0;
      // A local answer already stands one step after the take edge
      #1;
      while (mgmtAck !== 1'b1 && n < 30) begin
         @(posedge core_clk);
         #1 n++;
      end
      if (n == 30) begin
         err_total++;
         $display("unexpected at %0t: no answer", $time);
      end
      rd = mgmtRdata;
   endtask : acc
   task automatic rdchk(input logic [4:0] idx, input logic [15:0] e);
      acc(1'b0, idx, 16'h0000);
      `CHK(rd, e)
   endtask : rdchk
   task automatic setc(input logic [5:0] v);
      @(posedge core_clk);
      cond <= v;
      // Two sync stages plus one
      repeat (3) @(posedge core_clk);
   endtask : setc
   // Poll until a self-clearing bit drops, bounded
   task automatic waitClr(input int b);
      for (int k = 0; k < 20 && rd[b] !== 1'b0; k++) acc(1'b0, 5'h00, 16'h0000);
      `CHK(rd, 16'h1040)
   endtask : waitClr
   task automatic wrap_up();
      $display("compares %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         $display("unexpected at %0t: run too long", $time);
         wrap_up();
      end
   end
   initial begin
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      rdchk(5'h00, 16'h1040);
      rdchk(5'h01, 16'h7909);
      acc(1'b1, 5'h00, 16'h0100);
      rdchk(5'h00, 16'h0140);
      `CHK(modeCtl.forcedSpeed, phymm_pkg::SPEED_1000)
      `CHK(modeCtl.forcedDuplex, 1'b1)
      `CHK(modeCtl.forcedValid, 1'b1)
      acc(1'b1, 5'h00, 16'h2000);
      rdchk(5'h00, 16'h2040);
      `CHK(modeCtl.forcedSpeed, 2'h3)
      acc(1'b1, 5'h00, 16'h0800);
      rdchk(5'h00, 16'h0840);
      `CHK(modeCtl.powerDown, 1'b1)
      acc(1'b1, 5'h00, 16'h4000);
      rdchk(5'h00, 16'h4040);
      `CHK(modeCtl.loopback, 1'b1)
      acc(1'b1, 5'h00, 16'h1100);
      rdchk(5'h00, 16'h1140);
      `CHK(modeCtl.anEnable, 1'b1)
      `CHK(modeCtl.forcedValid, 1'b0)
      acc(1'b1, 5'h00, 16'hC100);
      rdchk(5'h00, 16'hC140);
      `CHK(modeCtl.softReset, 1'b1)
      waitClr(15);
      `CHK(modeCtl.softReset, 1'b0)
      acc(1'b1, 5'h00, 16'h1200);
      rdchk(5'h00, 16'h1240);
      `CHK(modeCtl.anRestart, 1'b1)
      waitClr(9);
      `CHK(modeCtl.anRestart, 1'b0)
      $display("test control done");
      setc(6'h3C);
      rdchk(5'h01, 16'h793B);
      rdchk(5'h01, 16'h793F);
      setc(6'h1C);
      rdchk(5'h01, 16'h793B);
      setc(6'h20);
      rdchk(5'h01, 16'h7909);
      rdchk(5'h01, 16'h790D);
      setc(6'h00);
      setc(6'h20);
      rdchk(5'h01, 16'h7909);
      rdchk(5'h01, 16'h790D);
      // A write offered while the clock enable is low must not land
      @(posedge core_clk);
      clkEn <= 1'b0;
      mgmtReq <= 1'b1;
      mgmtCmd <= '{write: 1'b1, index: 5'h00, wdata: 16'h4000};
      repeat (3) @(posedge core_clk);
      mgmtReq <= 1'b0;
      clkEn <= 1'b1;
      `CHK(mgmtAck, 1'b0)
      rdchk(5'h00, 16'h1040);
      $display("test status done");
      acc(1'b1, 5'h10, 16'hA1A1);
      acc(1'b1, 5'h1F, 16'h0001);
      acc(1'b1, 5'h10, 16'hB2B2);
      rdchk(5'h10, 16'hB2B2);
      acc(1'b1, 5'h05, 16'hC3C3);
      @(posedge core_clk);
      lat <= 4'h3;
      acc(1'b1, 5'h1F, 16'h0002);
      rdchk(5'h1F, 16'h0002);
      rdchk(5'h10, 16'h0000);
      acc(1'b1, 5'h10, 16'hD4D4);
      rdchk(5'h10, 16'hD4D4);
      rdchk(5'h00, 16'h1040);
      rdchk(5'h05, 16'hC3C3);
      acc(1'b1, 5'h1F, 16'h0000);
      rdchk(5'h10, 16'hA1A1);
      // Page values other than 1 and 2 keep the main page
      acc(1'b1, 5'h1F, 16'h0003);
      rdchk(5'h10, 16'hA1A1);
      $display("test paging done");
      wrap_up();
   end
endmodule : tb_top
